// ==== fcts_seq.sv ====
// Behaviour
// - clock notification finishes within 62.5 us at this clock setup
// - entry value aa00 returns to read mode; idle flag within erase bound
// - block erase finishes in at most 240 ms
// - 256-byte unit program finishes in at most 12 ms
`include "fcts_regs.svh"

module fcts_seq import fcts_pkg::*; #(
  parameter int unsigned ERASE_MAX_CYC = `FCTS_ERASE_MAX_CYC,
  parameter int unsigned PROG_MAX_CYC = `FCTS_PROG_MAX_CYC
) (
  input wire logic i_ref_clk,
  input wire logic i_arst_n,
  input wire fcts_cmd_t i_cmd,
  input wire logic i_macro_done,
  input wire logic i_sequencer_reset_bit,
  output logic o_sequencer_idle_flag,
  output logic o_read_mode,
  output logic o_op_forced
);

  localparam int unsigned TW = `FCTS_TIMER_W;
  localparam int unsigned NOTIFY_CYC = `FCTS_NOTIFY_CYC;

  fcts_state_t state_r;
  fcts_state_t state_nxt;
  logic ready_r;
  logic ready_nxt;
  logic read_mode_r;
  logic read_mode_nxt;
  logic pend_read_r;
  logic pend_read_nxt;
  logic forced_r;
  logic forced_nxt;
  logic start;
  logic [TW-1:0] cap;
  logic expired;
  logic done;
  logic entry_read;

  // ==========================================================
  // operation timer: forces completion at the worst-case bound
  fcts_op_timer #(.TW(TW)) u_timer (
    .i_ref_clk(i_ref_clk),
    .i_arst_n(i_arst_n),
    .i_start(start),
    .i_stop(i_macro_done || i_sequencer_reset_bit),
    .i_cap(cap),
    .o_expired(expired)
  );

  assign done = i_macro_done || expired;
  assign entry_read = i_cmd.valid && (i_cmd.kind == CMD_ENTRY) &&
                      (i_cmd.data == `FCTS_ENTRY_READ);

  // ==========================================================
  // sequencer control
  always_comb begin
    state_nxt = state_r;
    ready_nxt = ready_r;
    read_mode_nxt = read_mode_r;
    pend_read_nxt = pend_read_r;
    forced_nxt = 1'b0;
    start = 1'b0;
    cap = '0;
    if (i_sequencer_reset_bit) begin
      // reset bit aborts any operation and drops the idle flag
      state_nxt = ST_RESET;
      ready_nxt = 1'b0;
      pend_read_nxt = 1'b0;
    end else begin
      unique case (state_r)
        ST_RESET: begin
          state_nxt = ST_IDLE;
          ready_nxt = 1'b1;
          read_mode_nxt = 1'b1;
        end
        ST_IDLE: begin
          if (i_cmd.valid) begin
            unique case (i_cmd.kind)
              CMD_NOTIFY: begin
                start = 1'b1;
                cap = TW'(NOTIFY_CYC);
                state_nxt = ST_NOTIFY;
                ready_nxt = 1'b0;
              end
              CMD_ERASE: begin
                if (!read_mode_r) begin
                  start = 1'b1;
                  cap = TW'(ERASE_MAX_CYC);
                  state_nxt = ST_ERASE;
                  ready_nxt = 1'b0;
                end
              end
              CMD_PROGRAM: begin
                if (!read_mode_r) begin
                  start = 1'b1;
                  cap = TW'(PROG_MAX_CYC);
                  state_nxt = ST_PROGRAM;
                  ready_nxt = 1'b0;
                end
              end
              CMD_ENTRY: begin
                read_mode_nxt = entry_read;
              end
            endcase
          end
        end
        ST_NOTIFY, ST_ERASE, ST_PROGRAM: begin
          if (entry_read) begin
            pend_read_nxt = 1'b1;
          end
          if (done) begin
            state_nxt = ST_IDLE;
            ready_nxt = 1'b1;
            forced_nxt = expired && !i_macro_done;
            if (pend_read_r || entry_read) begin
              // read-mode return waits only for the running operation
              read_mode_nxt = 1'b1;
              pend_read_nxt = 1'b0;
            end
          end
        end
        default: begin
          state_nxt = ST_IDLE;
          ready_nxt = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      state_r <= ST_IDLE;
      ready_r <= 1'b1;
      read_mode_r <= 1'b1;
      pend_read_r <= 1'b0;
      forced_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      ready_r <= ready_nxt;
      read_mode_r <= read_mode_nxt;
      pend_read_r <= pend_read_nxt;
      forced_r <= forced_nxt;
    end
  end

  assign o_sequencer_idle_flag = ready_r;
  assign o_read_mode = read_mode_r;
  assign o_op_forced = forced_r;

  // ==========================================================
  // checks
  logic [31:0] busy_cnt_r;
  logic op_busy;

  assign op_busy = (state_r == ST_NOTIFY) || (state_r == ST_ERASE) ||
                   (state_r == ST_PROGRAM);

  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      busy_cnt_r <= '0;
    end else begin
      busy_cnt_r <= op_busy ? busy_cnt_r + 32'h1 : 32'h0;
    end
  end

  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_arst_n);

  chk_notify_bound: assert property (
    (state_r == ST_NOTIFY) |-> (busy_cnt_r < NOTIFY_CYC))
    else $error("clock notification overran its limit");

  chk_erase_bound: assert property (
    (state_r == ST_ERASE) |-> (busy_cnt_r < ERASE_MAX_CYC))
    else $error("block erase overran its limit");

  chk_prog_bound: assert property (
    (state_r == ST_PROGRAM) |-> (busy_cnt_r < PROG_MAX_CYC))
    else $error("unit program overran its limit");

  chk_entry_idle: assert property (
    (state_r == ST_IDLE && entry_read && !i_sequencer_reset_bit)
      |=> (o_read_mode && o_sequencer_idle_flag))
    else $error("read mode entry from idle not taken");

  chk_entry_pend: assert property (
    (op_busy && done && (pend_read_r || entry_read) && !i_sequencer_reset_bit)
      |=> (o_read_mode && o_sequencer_idle_flag && !pend_read_r))
    else $error("pending read mode entry lost at completion");

  chk_flag_low_busy: assert property (
    $rose(op_busy) |-> (!o_sequencer_idle_flag throughout op_busy[*2]) or
      ($rose(op_busy) ##1 !op_busy))
    else $error("idle flag high while operation runs");

  cov_notify_done: cover property ($fell(state_r == ST_NOTIFY) && ready_r);
  cov_forced: cover property (o_op_forced);
  cov_pend_read: cover property (pend_read_r ##1 o_read_mode);

endmodule // fcts_seq

// ==== fcts_regs.svh ====
`ifndef FCTS_REGS_SVH
`define FCTS_REGS_SVH

// ==========================================================
// clock and timing figures
`define FCTS_CLK_KHZ 20000
`define FCTS_NOTIFY_LIMIT_NS 62500
`define FCTS_NOTIFY_CYC ((`FCTS_NOTIFY_LIMIT_NS * `FCTS_CLK_KHZ) / 1000000)
`define FCTS_ERASE_MAX_MS 240
`define FCTS_ERASE_MAX_CYC (`FCTS_ERASE_MAX_MS * `FCTS_CLK_KHZ)
`define FCTS_PROG_MAX_MS 12
`define FCTS_PROG_MAX_CYC (`FCTS_PROG_MAX_MS * `FCTS_CLK_KHZ)
`define FCTS_TIMER_W 23

// ==========================================================
// entry register values
`define FCTS_ENTRY_READ 16'haa00

`endif

// ==== fcts_pkg.sv ====
package fcts_pkg;

  typedef enum logic [1:0] {
    CMD_NOTIFY = 2'h0,
    CMD_ERASE = 2'h1,
    CMD_PROGRAM = 2'h2,
    CMD_ENTRY = 2'h3
  } fcts_cmd_kind_t;

  typedef struct packed {
    logic valid;
    fcts_cmd_kind_t kind;
    logic [15:0] data;
  } fcts_cmd_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_NOTIFY = 3'h1,
    ST_ERASE = 3'h2,
    ST_PROGRAM = 3'h3,
    ST_RESET = 3'h4
  } fcts_state_t;

endpackage

// ==== fcts_op_timer.sv ====
// ==========================================================
// down counter that expires on the cap-th running cycle
module fcts_op_timer #(
  parameter int unsigned TW = 23
) (
  input wire logic i_ref_clk,
  input wire logic i_arst_n,
  input wire logic i_start,
  input wire logic i_stop,
  input wire logic [TW-1:0] i_cap,
  output logic o_expired
);

  logic [TW-1:0] cnt_r;
  logic [TW-1:0] cnt_nxt;
  logic run_r;
  logic run_nxt;

  always_comb begin
    cnt_nxt = cnt_r;
    run_nxt = run_r;
    if (i_start) begin
      cnt_nxt = i_cap - TW'(1);
      run_nxt = 1'b1;
    end else if (i_stop || (run_r && cnt_r == '0)) begin
      run_nxt = 1'b0;
    end else if (run_r) begin
      cnt_nxt = cnt_r - TW'(1);
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      cnt_r <= '0;
      run_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      run_r <= run_nxt;
    end
  end

  assign o_expired = run_r && (cnt_r == '0);

endmodule // fcts_op_timer

// ==== fcts_host_model.sv ====
// ==========================================================
// host side: issues commands, polls idle, pulses the reset bit
module fcts_host_model import fcts_pkg::*; (
  input wire logic i_ref_clk,
  input wire logic i_idle,
  output fcts_cmd_t o_cmd,
  output logic o_reset_bit
);
  timeunit 1ns;
  timeprecision 100ps;

  initial begin
    o_cmd = '0;
    o_reset_bit = 1'b0;
  end

  // one-cycle command; the payload is inverted once released
  task automatic issue(input fcts_cmd_kind_t k, input logic [15:0] d);
    @(negedge i_ref_clk);
    o_cmd = {1'b1, k, d};
    @(negedge i_ref_clk);
    o_cmd = {1'b0, k, ~d};
    @(negedge i_ref_clk);
  endtask

  // counts clock cycles rather than trusting loop timing
  task automatic wait_idle(input int lim, output int n, output bit late);
    n = 1;
    while (i_idle !== 1'b1 && n < lim) begin
      @(negedge i_ref_clk);
      n++;
    end
    late = (i_idle !== 1'b1);
  endtask

  task automatic reinit(input int hold);
    @(negedge i_ref_clk);
    o_reset_bit = 1'b1;
    repeat (hold) @(negedge i_ref_clk);
    o_reset_bit = 1'b0;
  endtask
endmodule // fcts_host_model

// ==== flash_command_timeout_supervisor_bench.sv ====
`include "fcts_regs.svh"

module flash_command_timeout_supervisor_bench;
  import fcts_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;

  localparam int ERASE_CYC = 40;
  localparam int PROG_CYC = 20;
  localparam int RST_CYC = 2100;

  logic ref_clk;
  logic arst_n;
  logic macro_done;
  logic reset_bit;
  logic idle;
  logic read_mode;
  logic op_forced;
  fcts_cmd_t cmd;
  int err_count = 0;
  int tests_run = 0;

  fcts_seq #(.ERASE_MAX_CYC(ERASE_CYC), .PROG_MAX_CYC(PROG_CYC)) i_dut (
    .i_ref_clk(ref_clk),
    .i_arst_n(arst_n),
    .i_cmd(cmd),
    .i_macro_done(macro_done),
    .i_sequencer_reset_bit(reset_bit),
    .o_sequencer_idle_flag(idle),
    .o_read_mode(read_mode),
    .o_op_forced(op_forced)
  );

  fcts_host_model u_host (
    .i_ref_clk(ref_clk),
    .i_idle(idle),
    .o_cmd(cmd),
    .o_reset_bit(reset_bit)
  );

  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end

  // ==========================================================
  // checking and closing
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic end_sim();
    $display("checks=%0d errors=%0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // ==========================================================
  // scenarios
  task automatic pulse_done(input int k);
    if (k > 1) begin
      repeat (k - 2) @(negedge ref_clk);
      macro_done = 1'b1;
      @(negedge ref_clk);
      macro_done = 1'b0;
    end
  endtask

  // k is the edge that reports completion, 0 for none
  task automatic t_op(input fcts_cmd_kind_t kd, input int k, input int exp, input logic fexp);
    int n;
    bit late;
    // the clock value travels with the notify command, ahead of its processing
    u_host.issue(kd, (kd == CMD_NOTIFY) ? 16'(`FCTS_CLK_KHZ) : 16'h0000);
    chk(32'(idle), 32'h0);
    fork
      u_host.wait_idle(3 * exp, n, late);
      pulse_done(k);
    join
    chk(32'(n), 32'(exp));
    chk(32'(late), 32'h0);
    chk(32'(op_forced), 32'(fexp));
    @(negedge ref_clk);
    chk(32'(op_forced), 32'h0);
  endtask

  task automatic t_entry(input logic [15:0] d, input logic exp);
    u_host.issue(CMD_ENTRY, d);
    chk(32'(read_mode), 32'(exp));
    chk(32'(idle), 32'h1);
  endtask

  task automatic t_entry_busy();
    u_host.issue(CMD_ERASE, 16'h0000);
    u_host.issue(CMD_ENTRY, `FCTS_ENTRY_READ);
    chk(32'(read_mode), 32'h0);
    chk(32'(idle), 32'h0);
    // completion is taken at the edge that samples it
    macro_done = 1'b1;
    @(negedge ref_clk);
    macro_done = 1'b0;
    chk(32'(idle), 32'h1);
    chk(32'(read_mode), 32'h1);
  endtask

  task automatic t_reinit();
    t_entry(16'h0000, 1'b0);
    u_host.issue(CMD_PROGRAM, 16'h0000);
    u_host.reinit(RST_CYC);
    chk(32'(idle), 32'h0);
    repeat (2) @(negedge ref_clk);
    chk(32'(idle), 32'h1);
    chk(32'(read_mode), 32'h1);
  endtask

  initial begin
    arst_n = 1'b0;
    macro_done = 1'b0;
    fork
      begin
        repeat (20000) @(posedge ref_clk);
        err_count++;
        end_sim();
      end
    join_none
    repeat (20) @(negedge ref_clk);
    arst_n = 1'b1;
    chk({29'h0, idle, read_mode, op_forced}, 32'h6);
    // the wait count is the number of cycles from the taking edge to the flag
    t_op(CMD_NOTIFY, 0, `FCTS_NOTIFY_CYC, 1'b1);
    t_op(CMD_NOTIFY, 3, 3, 1'b0);
    u_host.issue(CMD_ERASE, 16'h0000);
    chk(32'(idle), 32'h1);
    t_entry(16'h0000, 1'b0);
    t_op(CMD_ERASE, 0, ERASE_CYC, 1'b1);
    t_op(CMD_PROGRAM, 0, PROG_CYC, 1'b1);
    t_op(CMD_PROGRAM, 3, 3, 1'b0);
    t_entry_busy();
    t_reinit();
    end_sim();
  end
endmodule // flash_command_timeout_supervisor_bench
